// file: design/primary_status_pkg.sv
// Constants for the primary-interface status register of the bridge.
// Assumes a 16-bit configuration word access decoded by the surrounding config logic.
package primary_status_pkg;
   localparam logic [7:0] STATUS_OFFSET = 8'h06;
   localparam logic [7:0] COMMAND_OFFSET = 8'h04;
   localparam int BIT_PARITY_DETECTED = 15;
   localparam int BIT_SYSERR_SIGNALLED = 14;
   localparam int BIT_MASTER_ABORT_RCVD = 13;
   localparam int BIT_TARGET_ABORT_RCVD = 12;
   localparam int BIT_TARGET_ABORT_SENT = 11;
   localparam int BIT_SEL_TIMING_HI = 10;
   localparam int BIT_SEL_TIMING_LO = 9;
   localparam int BIT_DATA_PARITY = 8;
   localparam int BIT_FAST_B2B = 7;
   localparam int BIT_USER_FEATURE = 6;
   localparam int BIT_SPEED_66 = 5;
   localparam int BIT_CAP_LIST = 4;
   localparam int BIT_RESERVED_HI = 3;
   localparam int CMD_BIT_PARITY_RESP = 6;
   localparam int CMD_BIT_SYSERR_EN = 8;
   localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
   localparam logic FAST_B2B_VALUE = 1'h1;
   localparam logic USER_FEATURE_VALUE = 1'h0;
   localparam logic CAP_LIST_VALUE = 1'h1;
   localparam logic [3:0] RESERVED_VALUE = 4'h0;
   localparam logic [15:0] COMMAND_RESET = 16'h0000;
   localparam logic [15:0] COMMAND_WRITABLE = 16'h0367;
endpackage

// file: design/primary_status_reg.sv
// Primary bus status register with the command bits that steer it.
// Assumes event strobes are one-cycle pulses from primary bus logic on clk;
// the speed strap is an asynchronous pin and is synchronised here.
// Functional notes
// - Parity error detected sets bit 15
// - SERR asserted while enabled sets bit 14
// - Received master abort sets bit 13
// - Received target abort sets bit 12
// - Signalled target abort sets bit 11
// - Bits 10-9 read fixed 01b
// - Bit 8 needs PERR, mastership, response enable
// - Bit 7 fast back-to-back reads 1
// - Bit 6 user feature reads 0
// - Bit 5 follows speed strap pin
// - Bit 4 capabilities list reads 1
// - Bits 3-0 read zero
// - Writing 1 clears flag, 0 ignored
// - Command bit 8 gates SERR driver
module primary_status_reg
   import primary_status_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [15:0] cfgWdata,
   output logic [15:0] cfgRdata,
   input wire logic parityErrDetected,
   input wire logic serrRequest,
   input wire logic masterAbortRcvd,
   input wire logic targetAbortRcvd,
   input wire logic targetAbortSent,
   input wire logic dataParityErr,
   input wire logic primary_parity_err_line,
   input wire logic busMaster,
   input wire logic speed_strap_pin,
   output logic serrOut,
   output logic serrOe_n,
   output logic [15:0] commandReg
);
   import primary_status_pkg::*;

   // Offset match, shared by write and read decode
   function automatic logic hitOffset(input logic [7:0] addr, input logic [7:0] offset);
      return addr == offset;
   endfunction

   // Sticky update; set is ored in last so it beats a clear in the same cycle
   function automatic logic nextSticky(input logic flag, input logic set, input logic clr);
      return (flag && !clr) || set;
   endfunction

   logic [15:0] command;
   logic [15:0] next_command;
   logic parityFlag;
   logic serrFlag;
   logic masterAbortFlag;
   logic targetAbortRcvdFlag;
   logic targetAbortSentFlag;
   logic dataParityFlag;
   logic next_parityFlag;
   logic next_serrFlag;
   logic next_masterAbortFlag;
   logic next_targetAbortRcvdFlag;
   logic next_targetAbortSentFlag;
   logic next_dataParityFlag;
   logic strapMeta;
   logic strapSync;
   logic [15:0] statusValue;
   logic [15:0] readValue;
   logic serrNow;
   logic dpSet;
   logic statusWr;
   logic commandWr;
   logic clrParity;
   logic clrSerr;
   logic clrMasterAbort;
   logic clrTargetAbortRcvd;
   logic clrTargetAbortSent;
   logic clrDataParity;

   assign statusWr = cfgWrite && hitOffset(cfgAddr, STATUS_OFFSET);
   assign commandWr = cfgWrite && hitOffset(cfgAddr, COMMAND_OFFSET);
   assign next_command = commandWr ? (cfgWdata & COMMAND_WRITABLE) : command;

   // Driver only fires while enabled, so the flag only sees enabled SERR
   assign serrNow = serrRequest && command[CMD_BIT_SYSERR_EN];
   // All four conditions must meet in one cycle; the parity line is on clk
   assign dpSet = dataParityErr && primary_parity_err_line && busMaster
                  && command[CMD_BIT_PARITY_RESP];

   // Write-one-to-clear strobes, one per writable status bit
   assign clrParity = statusWr && cfgWdata[BIT_PARITY_DETECTED];
   assign clrSerr = statusWr && cfgWdata[BIT_SYSERR_SIGNALLED];
   assign clrMasterAbort = statusWr && cfgWdata[BIT_MASTER_ABORT_RCVD];
   assign clrTargetAbortRcvd = statusWr && cfgWdata[BIT_TARGET_ABORT_RCVD];
   assign clrTargetAbortSent = statusWr && cfgWdata[BIT_TARGET_ABORT_SENT];
   assign clrDataParity = statusWr && cfgWdata[BIT_DATA_PARITY];

   assign next_parityFlag = nextSticky(parityFlag, parityErrDetected, clrParity);
   assign next_serrFlag = nextSticky(serrFlag, serrNow, clrSerr);
   assign next_masterAbortFlag = nextSticky(masterAbortFlag, masterAbortRcvd,
                                            clrMasterAbort);
   assign next_targetAbortRcvdFlag = nextSticky(targetAbortRcvdFlag, targetAbortRcvd,
                                                clrTargetAbortRcvd);
   assign next_targetAbortSentFlag = nextSticky(targetAbortSentFlag, targetAbortSent,
                                                clrTargetAbortSent);
   assign next_dataParityFlag = nextSticky(dataParityFlag, dpSet, clrDataParity);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         command <= COMMAND_RESET;
      end else begin
         command <= next_command;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         parityFlag <= 1'h0;
      end else begin
         parityFlag <= next_parityFlag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serrFlag <= 1'h0;
      end else begin
         serrFlag <= next_serrFlag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         masterAbortFlag <= 1'h0;
      end else begin
         masterAbortFlag <= next_masterAbortFlag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         targetAbortRcvdFlag <= 1'h0;
      end else begin
         targetAbortRcvdFlag <= next_targetAbortRcvdFlag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         targetAbortSentFlag <= 1'h0;
      end else begin
         targetAbortSentFlag <= next_targetAbortSentFlag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataParityFlag <= 1'h0;
      end else begin
         dataParityFlag <= next_dataParityFlag;
      end
   end

   // Strap is a pin; bit 5 is only valid two edges after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta <= 1'h0;
         strapSync <= 1'h0;
      end else begin
         strapMeta <= speed_strap_pin;
         strapSync <= strapMeta;
      end
   end

   always_comb begin
      statusValue = 16'h0000;
      statusValue[BIT_PARITY_DETECTED] = parityFlag;
      statusValue[BIT_SYSERR_SIGNALLED] = serrFlag;
      statusValue[BIT_MASTER_ABORT_RCVD] = masterAbortFlag;
      statusValue[BIT_TARGET_ABORT_RCVD] = targetAbortRcvdFlag;
      statusValue[BIT_TARGET_ABORT_SENT] = targetAbortSentFlag;
      statusValue[BIT_SEL_TIMING_HI:BIT_SEL_TIMING_LO] = SEL_TIMING_MEDIUM;
      statusValue[BIT_DATA_PARITY] = dataParityFlag;
      statusValue[BIT_FAST_B2B] = FAST_B2B_VALUE;
      statusValue[BIT_USER_FEATURE] = USER_FEATURE_VALUE;
      statusValue[BIT_SPEED_66] = strapSync;
      statusValue[BIT_CAP_LIST] = CAP_LIST_VALUE;
      statusValue[BIT_RESERVED_HI:0] = RESERVED_VALUE;
   end

   // Unmapped offsets return zero
   always_comb begin
      readValue = 16'h0000;
      if (hitOffset(cfgAddr, STATUS_OFFSET)) begin
         readValue = statusValue;
      end else if (hitOffset(cfgAddr, COMMAND_OFFSET)) begin
         readValue = command;
      end
   end

   // Read data registered, so it shows the flags as they stood before the read edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgRdata <= 16'h0000;
      end else if (cfgRead) begin
         cfgRdata <= readValue;
      end
   end

   // Open-drain style pin: the value is high in reset and low after it, the enable does the signalling
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serrOut <= 1'h1;
      end else begin
         serrOut <= 1'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serrOe_n <= 1'h1;
      end else begin
         serrOe_n <= !serrNow;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         commandReg <= COMMAND_RESET;
      end else begin
         commandReg <= command;
      end
   end
endmodule

// file: testbench/bus_agent_model.sv
// Primary bus agent: event strobes.
// Assumes requests change at the falling edge.
module bus_agent_model(
   input wire logic [7:0] req,
   output logic [7:0] ev
);
   timeunit 1ns;
   timeprecision 1ps;
   assign ev = req;
endmodule

// file: testbench/primary_status_chk.sv
// Status register port checks.
// Assumes reads answer one cycle late.
module primary_status_chk(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [15:0] cfgWdata,
   input wire logic [15:0] cfgRdata,
   input wire logic parityErrDetected,
   input wire logic serrRequest,
   input wire logic masterAbortRcvd,
   input wire logic serrOe_n,
   input wire logic [15:0] commandReg
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rdStatus;
   assign rdStatus = cfgRead && cfgAddr == 8'h06;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence rd;
      rdStatus;
   endsequence
   chk_parity_set: assert property (parityErrDetected ##1 rd |=> cfgRdata[15])
      else $error("bit15");
   // commandReg trails the live command bits by one cycle
   chk_serr_flag: assert property (serrRequest ##1 commandReg[8] ##0 rd |=> cfgRdata[14])
      else $error("bit14");
   chk_mabort_set: assert property (masterAbortRcvd ##1 rd |=> cfgRdata[13])
      else $error("bit13");
   chk_fixed_bits: assert property (rd |=> cfgRdata[10:9] == 2'h1 &&
      cfgRdata[7:6] == 2'h2 && cfgRdata[4:0] == 5'h10) else $error("fixed");
   chk_serr_drive: assert property (serrOe_n == !($past(serrRequest) && commandReg[8]))
      else $error("serr");
   chk_flag_clear: assert property (cfgWrite && cfgAddr == 8'h06 && cfgWdata[13] &&
      !masterAbortRcvd ##1 rd |=> !cfgRdata[13]) else $error("clear");
   chk_flag_sticky: assert property (rdStatus && !(cfgWrite && cfgWdata[15]) ##1
      cfgRdata[15] && rdStatus |=> cfgRdata[15]) else $error("sticky");
   chk_cmd_mask: assert property (cfgWrite && cfgAddr == 8'h04 |=> ##1
      commandReg == ($past(cfgWdata, 2) & 16'h0367)) else $error("cmd");
endmodule
bind primary_status_reg primary_status_chk u_chk(.clk, .rst_n, .cfgRead, .cfgWrite, .cfgAddr,
   .cfgWdata, .cfgRdata, .parityErrDetected, .serrRequest, .masterAbortRcvd, .serrOe_n,
   .commandReg);

// file: testbench/tb.sv
// Random bench with a reference model.
// Assumes the strap changes only while reset is held.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, cfgWrite = 0, cfgRead = 0, strap = 0, run = 0, serrOe_n, serrOut;
   logic [7:0] cfgAddr = 0, req = 0, ev;
   logic [15:0] cfgWdata = 0, cfgRdata, commandReg;
   logic [31:0] r;
   int seed = 632, num_errors = 0, n_compared = 0, stat = 0, cmd = 0, cmdQ = 0, expRd = 0;
   int rdPend = 0, expOe = 1;
   bus_agent_model u_agent(.req, .ev);
   primary_status_reg u_dut(.clk, .rst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgRdata,
      .parityErrDetected(ev[0]), .serrRequest(ev[1]), .masterAbortRcvd(ev[2]),
      .targetAbortRcvd(ev[3]), .targetAbortSent(ev[4]), .dataParityErr(ev[5]),
      .primary_parity_err_line(ev[6]), .busMaster(ev[7]), .speed_strap_pin(strap),
      .serrOut, .serrOe_n, .commandReg);
   task automatic check(input string name, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial forever #4 clk = ~clk;
   // Registered outputs take the value before this edge; set beats clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat = 0;
         cmd = 0;
         cmdQ = 0;
         rdPend = 0;
         expOe = 1;
      end else begin
         if (cfgRead) expRd = cfgAddr == 8'h06 ? stat | 16'h0290 | strap << 5 :
            cfgAddr == 8'h04 ? cmd : 0;
         rdPend = cfgRead;
         cmdQ = cmd;
         expOe = !(ev[1] & cmd[8]);
         if (cfgWrite && cfgAddr == 8'h06) stat = stat & ~(cfgWdata & 16'hf900);
         stat = stat | ev[0] << 15 | (ev[1] & cmd[8]) << 14 | ev[2] << 13 | ev[3] << 12 |
            ev[4] << 11 | (&ev[7:5] & cmd[6]) << 8;
         if (cfgWrite && cfgAddr == 8'h04) cmd = cfgWdata & 16'h0367;
      end
   end
   always @(negedge clk) begin
      if (run) begin
         check("command", commandReg, cmdQ[15:0]);
         check("serr_oe", {15'h0, serrOe_n}, expOe[15:0]);
         check("serr_out", {15'h0, serrOut}, 16'h0000);
         if (rdPend) check("readback", cfgRdata, expRd[15:0]);
         r = $random(seed);
         cfgRead <= r[0];
         cfgWrite <= r[1] & r[2];
         cfgAddr <= r[4] ? 8'h06 : r[3] ? 8'h04 : 8'h02;
         cfgWdata <= r[31:16];
         req <= {r[15:14], r[13:8] & r[21:16]};
      end else begin
         cfgRead <= 1'b0;
         cfgWrite <= 1'b0;
         req <= 8'h00;
      end
   end
   // Two reset phases, the second with the strap inverted, so bit 5 is seen both ways
   initial begin
      strap = 1'($random(seed));
      repeat (2) begin
         repeat (8) @(posedge clk);
         @(negedge clk);
         rst_n = 1;
         repeat (3) @(posedge clk);
         run = 1;
         repeat (1500) @(posedge clk);
         @(negedge clk);
         run <= 0;
         @(negedge clk);
         rst_n = 0;
         strap = ~strap;
      end
      finish_test();
   end
endmodule
